// ==== hdl/hspc_ctrl.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "hspc_regs.svh"
module hspc_ctrl
   import hspc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic halt_cmd,
   input wire logic stop_cmd,
   input wire logic [3:0] operand,
   input wire logic instr_done,
   input wire logic [3:0] wake_input_port,
   input wire logic [`HSPC_NSRC-1:0] irq_set,
   input wire logic [`HSPC_NSRC-1:0] irq_clr,
   input wire logic [`HSPC_NSRC-1:0] irq_source_enable,
   input wire logic [`HSPC_NSRC-1:0] ext_pins,
   input wire logic ce_pin,
   input wire logic ce_counter_running,
   input wire logic [1:0] interval_sel,
   input wire logic interval_carry_clr,
   input wire logic [15:0] settle_cycles,
   output logic core_clk_en,
   output logic osc_en,
   output logic pfd_en,
   output logic periph_init,
   output logic interval_carry_flag,
   output logic enable_counter_active_flag,
   output logic [`HSPC_NSRC-1:0] irq_request_flag,
   output logic [3:0] wake_port_seen,
   output logic irq_wake,
   output logic halted
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   hspc_state_t st_q, st_d;
   logic [3:0] sel_q, sel_d;
   logic [15:0] cnt_q, cnt_d;
   logic [`HSPC_NSRC-1:0] irq_q, irq_d, pend_q, pend_d, pins_q;
   logic [17:0] tick_q, tick_d;
   logic [3:0] div_q, div_d;
   logic carry_q, carry_d, ce_q;
   logic [3:0] port_q, port_d;
   logic iw_q, iw_d, init_q, init_d;
   logic [`HSPC_NSRC-1:0] fall;
   logic port_hi, any_irq, halt_wake, stop_wake, ce_rise;
   logic [3:0] div_lim;

   generate
      genvar i;
      for (i = 0; i < `HSPC_NSRC; i = i + 1)
      begin : g_src
         assign fall[i] = pins_q[i] & ~ext_pins[i];
      end
   endgenerate

   assign port_hi = |wake_input_port;
   assign any_irq = |(irq_q & irq_source_enable);
   assign ce_rise = ce_pin & ~ce_q;
   // Port wake, timer carry and accepted interrupt each select independently.
   assign halt_wake = (sel_q[`HSPC_SEL_PORT] & port_hi) | (sel_q[`HSPC_SEL_TIMER] & carry_q)
                    | (sel_q[`HSPC_SEL_IRQ] & any_irq);
   // A zero operand gives no term here, so only rst leaves stop.
   assign stop_wake = (sel_q[`HSPC_SEL_PORT] & port_hi)
                    | (sel_q[`HSPC_SEL_IRQ] & (|((irq_q | fall) & irq_source_enable)));

   always_comb
   begin
      case (interval_sel)
         2'b00: div_lim = `HSPC_CNT100;
         2'b01: div_lim = `HSPC_CNT50;
         2'b10: div_lim = `HSPC_CNT20;
         default: div_lim = `HSPC_ONE4;
      endcase
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      st_d = st_q;
      sel_d = sel_q;
      cnt_d = cnt_q;
      port_d = port_q;
      iw_d = iw_q;
      init_d = 1'b0;
      tick_d = tick_q;
      div_d = div_q;
      carry_d = carry_q & ~interval_carry_clr;
      // Clears are delayed by one instruction so a clear right before standby still wakes.
      pend_d = instr_done ? irq_clr : (pend_q | irq_clr);
      irq_d = (irq_q & ~(instr_done ? pend_q : `HSPC_ZERO6)) | irq_set | fall;
      if (st_q != HSPC_STOP)
      begin
         if (tick_q == `HSPC_TICKS_10MS - `HSPC_ONE18)
         begin
            tick_d = `HSPC_ZERO18;
            if (div_q >= div_lim - `HSPC_ONE4)
            begin
               div_d = `HSPC_ZERO4;
               carry_d = 1'b1;
            end
            else
               div_d = div_q + `HSPC_ONE4;
         end
         else
            tick_d = tick_q + `HSPC_ONE18;
      end
      case (st_q)
         HSPC_RUN:
         begin
            if (stop_cmd && !ce_rise && !ce_counter_running)
            begin
               st_d = HSPC_STOP;
               sel_d = operand;
               init_d = 1'b1;
               iw_d = 1'b0;
            end
            else if (halt_cmd)
            begin
               st_d = HSPC_HALT;
               sel_d = operand;
               iw_d = 1'b0;
            end
         end
         HSPC_HALT:
         begin
            if (halt_wake)
            begin
               st_d = HSPC_RUN;
               port_d = wake_input_port;
               iw_d = sel_q[`HSPC_SEL_IRQ] & any_irq;
            end
         end
         HSPC_STOP:
         begin
            if (stop_wake)
            begin
               st_d = HSPC_SETTLE;
               cnt_d = {1'b0, settle_cycles[15:1]};
               port_d = wake_input_port;
            end
         end
         HSPC_SETTLE:
         begin
            if (cnt_q <= `HSPC_ONE16)
            begin
               st_d = HSPC_RUN;
               cnt_d = `HSPC_ZERO16;
            end
            else
               cnt_d = cnt_q - `HSPC_ONE16;
         end
         default: st_d = HSPC_RUN;
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         st_q <= HSPC_RUN;
         sel_q <= `HSPC_ZERO4;
         cnt_q <= `HSPC_ZERO16;
         irq_q <= `HSPC_ZERO6;
         pend_q <= `HSPC_ZERO6;
         pins_q <= `HSPC_ZERO6;
         tick_q <= `HSPC_ZERO18;
         div_q <= `HSPC_ZERO4;
         carry_q <= 1'b0;
         ce_q <= 1'b0;
         port_q <= `HSPC_ZERO4;
         iw_q <= 1'b0;
         init_q <= 1'b0;
         core_clk_en <= 1'b1;
         osc_en <= 1'b1;
         pfd_en <= 1'b1;
         enable_counter_active_flag <= 1'b0;
         halted <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         sel_q <= sel_d;
         cnt_q <= cnt_d;
         irq_q <= irq_d;
         pend_q <= pend_d;
         pins_q <= ext_pins;
         tick_q <= tick_d;
         div_q <= div_d;
         carry_q <= carry_d;
         ce_q <= ce_pin;
         port_q <= port_d;
         iw_q <= iw_d;
         init_q <= init_d;
         core_clk_en <= (st_d == HSPC_RUN);
         osc_en <= (st_d != HSPC_STOP);
         pfd_en <= (st_d != HSPC_STOP);
         enable_counter_active_flag <= ce_counter_running;
         halted <= (st_d != HSPC_RUN);
      end
   end

   assign periph_init = init_q;
   assign interval_carry_flag = carry_q;
   assign irq_request_flag = irq_q;
   assign wake_port_seen = port_q;
   assign irq_wake = iw_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_stop_go;
      (st_q == HSPC_RUN) && stop_cmd && !ce_rise && !ce_counter_running;
   endsequence

   // A wake on the very next cycle is legal, so entry is judged in one cycle only.
   sequence s_stop_in;
      (st_q == HSPC_STOP) && periph_init && !osc_en && !pfd_en && !core_clk_en;
   endsequence

   sequence s_halt_port;
      (st_q == HSPC_HALT) && sel_q[`HSPC_SEL_PORT] && port_hi;
   endsequence

   sequence s_stop_irq;
      (st_q == HSPC_STOP) && sel_q[`HSPC_SEL_IRQ] && any_irq;
   endsequence

   AST_STOP_ENTER: assert property (@(posedge ref_clk) disable iff (rst)
      s_stop_go |=> s_stop_in)
      else $error("stop not entered");
   AST_STOP_NOP: assert property (@(posedge ref_clk) disable iff (rst)
      (st_q == HSPC_RUN) && stop_cmd && ce_counter_running |=> st_q != HSPC_STOP)
      else $error("stop not suppressed");
   AST_CE_RISE_NOP: assert property (@(posedge ref_clk) disable iff (rst)
      (st_q == HSPC_RUN) && stop_cmd && ce_rise |=> st_q != HSPC_STOP)
      else $error("stop not suppressed on enable rise");
   AST_CLK_OFF: assert property (@(posedge ref_clk) disable iff (rst)
      (st_q == HSPC_STOP) && $past(st_q == HSPC_STOP) |-> !core_clk_en && !pfd_en)
      else $error("clock running in stop");
   AST_RUN_CLK: assert property (@(posedge ref_clk) disable iff (rst)
      (st_q == HSPC_RUN) |-> core_clk_en && osc_en && pfd_en && !halted)
      else $error("clock enables low while running");
   AST_ZERO_STAY: assert property (@(posedge ref_clk) disable iff (rst)
      (st_q == HSPC_STOP) && (sel_q == `HSPC_ZERO4) |=> st_q == HSPC_STOP)
      else $error("stop left with zero operand");
   AST_STOP_WAKE: assert property (@(posedge ref_clk) disable iff (rst)
      (st_q == HSPC_STOP) && sel_q[`HSPC_SEL_PORT] && port_hi |=> st_q == HSPC_SETTLE)
      else $error("port wake missed");
   AST_STOP_IRQ: assert property (@(posedge ref_clk) disable iff (rst)
      s_stop_irq |=> st_q == HSPC_SETTLE)
      else $error("interrupt stop wake missed");
   AST_HALT_WAKE: assert property (@(posedge ref_clk) disable iff (rst)
      (st_q == HSPC_HALT) && sel_q[`HSPC_SEL_TIMER] && carry_q |=> st_q == HSPC_RUN)
      else $error("halt wake missed");
   AST_IRQ_HALT: assert property (@(posedge ref_clk) disable iff (rst)
      (st_q == HSPC_HALT) && sel_q[`HSPC_SEL_IRQ] && any_irq |=> irq_wake)
      else $error("irq wake missed");
   AST_PORT_SEEN: assert property (@(posedge ref_clk) disable iff (rst)
      s_halt_port |=> (st_q == HSPC_RUN) && (wake_port_seen == $past(wake_input_port)))
      else $error("wake port value not kept");
   AST_SETTLE: assert property (@(posedge ref_clk) disable iff (rst)
      (st_q == HSPC_SETTLE) && (cnt_q > `HSPC_ONE16) |=> st_q == HSPC_SETTLE)
      else $error("settle cut short");
   AST_CE_FLAG: assert property (@(posedge ref_clk) disable iff (rst)
      ce_counter_running |=> enable_counter_active_flag)
      else $error("ce flag wrong");
   AST_CLR_LATE: assert property (@(posedge ref_clk) disable iff (rst)
      irq_clr[0] && irq_q[0] && !instr_done |=> irq_q[0])
      else $error("clear too early");
   AST_SET_WINS: assert property (@(posedge ref_clk) disable iff (rst)
      irq_set[0] |=> irq_q[0])
      else $error("request set lost");
   AST_INIT_PULSE: assert property (@(posedge ref_clk) disable iff (rst)
      periph_init |=> !periph_init)
      else $error("peripheral init longer than one cycle");
endmodule
`default_nettype wire

// ==== hdl/hspc_pkg.sv ====
package hspc_pkg;
   typedef enum logic [1:0]
   {
      HSPC_RUN = 2'b00,
      HSPC_HALT = 2'b01,
      HSPC_STOP = 2'b10,
      HSPC_SETTLE = 2'b11
   } hspc_state_t;
endpackage

// ==== hdl/hspc_regs.svh ====
`ifndef HSPC_REGS_SVH
`define HSPC_REGS_SVH
`define HSPC_SEL_PORT 0
`define HSPC_SEL_TIMER 1
`define HSPC_SEL_IRQ 3
`define HSPC_NSRC 6
`define HSPC_ZERO4 4'h0
`define HSPC_ZERO6 6'h00
`define HSPC_ZERO16 16'h0000
`define HSPC_ONE16 16'h0001
`define HSPC_TICKS_10MS 18'h30D40
`define HSPC_ZERO18 18'h00000
`define HSPC_ONE18 18'h00001
`define HSPC_ONE4 4'h1
`define HSPC_CNT100 4'hA
`define HSPC_CNT50 4'h5
`define HSPC_CNT20 4'h2
`endif

// ==== test/hspc_ctrl_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module hspc_ctrl_tb_top
   import hspc_pkg::*;
;
   // ------------------------------------------------------------
   // Stimulus and observation
   // ------------------------------------------------------------
   logic ref_clk = 1'b0, rst = 1'b1, halt_cmd = 1'b0, stop_cmd = 1'b0, done = 1'b0, ce_run = 1'b0, ce = 1'b0;
   logic [3:0] operand = 4'h0, port = 4'h0, seen;
   logic [5:0] irq_set = 6'h00, irq_clr = 6'h00, irq_en = 6'h00, pins = 6'h3F, req;
   logic core_en, osc_en, pfd_en, p_init, carry, ce_flag, irq_wake, halted;
   int bad_count = 0;
   int total_checks = 0;
   always #25 ref_clk = ~ref_clk;
   // A short settle count keeps the stop walks brief; half of it is 8 cycles.
   hspc_ctrl u_dut (.ref_clk(ref_clk), .rst(rst), .halt_cmd(halt_cmd), .stop_cmd(stop_cmd),
      .operand(operand), .instr_done(done), .wake_input_port(port), .irq_set(irq_set),
      .irq_clr(irq_clr), .irq_source_enable(irq_en), .ext_pins(pins), .ce_pin(ce),
      .ce_counter_running(ce_run), .interval_sel(2'h0), .interval_carry_clr(1'b0),
      .settle_cycles(16'h0010), .core_clk_en(core_en), .osc_en(osc_en), .pfd_en(pfd_en),
      .periph_init(p_init), .interval_carry_flag(carry), .enable_counter_active_flag(ce_flag),
      .irq_request_flag(req), .wake_port_seen(seen), .irq_wake(irq_wake), .halted(halted));
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [5:0] got, input logic [5:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic cmd(input logic h, input logic s, input logic [3:0] op);
      @(posedge ref_clk);
      halt_cmd <= h;
      stop_cmd <= s;
      operand <= op;
      @(posedge ref_clk);
      halt_cmd <= 1'b0;
      stop_cmd <= 1'b0;
      #1;
   endtask
   task automatic wait_run(input int lim);
      int n;
      n = 0;
      while (halted !== 1'b0 && n < lim)
      begin
         step(1);
         n++;
      end
      if (n >= lim)
      begin
         bad_count++;
         $display("BAD t=%0t no return to run", $time);
         give_verdict();
      end
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_stop_port();
      cmd(1'b0, 1'b1, 4'h1);
      chk({2'b00, core_en, osc_en, pfd_en, p_init}, 6'h01);
      step(4);
      chk({5'h00, halted}, 6'h01);
      @(posedge ref_clk) port <= 4'h2;
      step(8);
      chk({5'h00, halted}, 6'h01);
      step(1);
      wait_run(8);
      chk({3'h0, core_en, osc_en, pfd_en}, 6'h07);
      @(posedge ref_clk) port <= 4'h0;
   endtask
   task automatic t_stop_irq();
      cmd(1'b0, 1'b1, 4'h9);
      @(posedge ref_clk) pins <= 6'h3E;
      step(5);
      chk({5'h00, halted}, 6'h01);
      @(posedge ref_clk) pins <= 6'h3F;
      irq_en <= 6'h01;
      @(posedge ref_clk) pins <= 6'h3E;
      wait_run(20);
      @(posedge ref_clk) pins <= 6'h3F;
   endtask
   task automatic t_stop_none();
      cmd(1'b0, 1'b1, 4'h0);
      @(posedge ref_clk) port <= 4'hF;
      pins <= 6'h3E;
      step(12);
      chk({5'h00, halted}, 6'h01);
      @(posedge ref_clk) rst <= 1'b1;
      port <= 4'h0;
      pins <= 6'h3F;
      step(2);
      rst <= 1'b0;
      step(1);
      chk({4'h0, halted, osc_en}, 6'h01);
   endtask
   task automatic t_stop_ce();
      @(posedge ref_clk) ce_run <= 1'b1;
      step(2);
      chk({5'h00, ce_flag}, 6'h01);
      cmd(1'b0, 1'b1, 4'h1);
      chk({4'h0, halted, osc_en}, 6'h01);
      @(posedge ref_clk) ce_run <= 1'b0;
      ce <= 1'b1;
      stop_cmd <= 1'b1;
      @(posedge ref_clk) stop_cmd <= 1'b0;
      ce <= 1'b0;
      #1;
      chk({4'h0, halted, ce_flag}, 6'h00);
   endtask
   task automatic t_halt();
      cmd(1'b1, 1'b0, 4'h1);
      chk({4'h0, halted, osc_en}, 6'h03);
      @(posedge ref_clk) port <= 4'h5;
      wait_run(5);
      chk({2'b00, seen}, 6'h05);
      @(posedge ref_clk) port <= 4'h0;
      irq_en <= 6'h02;
      irq_clr <= 6'h3F;
      done <= 1'b1;
      @(posedge ref_clk) irq_clr <= 6'h00;
      done <= 1'b0;
      cmd(1'b1, 1'b0, 4'hB);
      @(posedge ref_clk) irq_set <= 6'h02;
      @(posedge ref_clk) irq_set <= 6'h00;
      wait_run(5);
      chk({5'h00, irq_wake}, 6'h01);
      @(posedge ref_clk) irq_clr <= 6'h02;
      @(posedge ref_clk) irq_clr <= 6'h00;
      cmd(1'b1, 1'b0, 4'h8);
      wait_run(4);
      chk(req, 6'h02);
      @(posedge ref_clk) done <= 1'b1;
      @(posedge ref_clk) done <= 1'b0;
      step(2);
      chk(req, 6'h00);
   endtask
   initial
   begin
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      step(1);
      chk({1'b0, carry, core_en, osc_en, pfd_en, halted}, 6'h0E);
      t_stop_port();
      t_stop_irq();
      t_stop_none();
      t_stop_ce();
      t_halt();
      give_verdict();
   end
endmodule
`default_nettype wire
